// File: design/wwdt_pkg.sv
// package for the windowed watchdog: register map, field layout, reset values, timing
// assumes a 32-bit plain register port and a 40 MHz system clock
package wwdt_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] CTRL_CLR_OFS = 4'h4;
  localparam logic [3:0] CTRL_SET_OFS = 4'h8;
  localparam logic [3:0] CTRL_INV_OFS = 4'hc;

  // ****************************************
  // field positions
  // ****************************************
  localparam int ON_POS = 15;
  localparam int PS_LSB = 2;
  localparam int PS_MSB = 6;
  localparam int WIN_POS = 1;
  localparam int CLR_POS = 0;

  // ****************************************
  // reset values and timing
  // ****************************************
  localparam logic ON_RST = 1'b0;
  localparam logic WIN_RST = 1'b0;
  localparam int SYS_CLK_HZ = 40000000;
  localparam int LPOSC_HZ = 32000;
  localparam int LPOSC_DIV = SYS_CLK_HZ / LPOSC_HZ;
  localparam logic [10:0] LPOSC_DIV_LAST = 11'(LPOSC_DIV - 1);
  // edges after reset release before the strap synchroniser has settled
  localparam logic [10:0] STRAP_SETTLE = 11'h2;
  // window opens in the last quarter of the period
  localparam int WIN_SHIFT = 2;

  typedef enum logic [1:0] {
    WWDT_RUN = 2'b00,
    WWDT_EXPIRED = 2'b01,
    WWDT_STOPPED = 2'b10
  } wwdt_mode_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } wwdt_bus_t;

  typedef struct packed {
    logic sw_on;
    logic win_en;
    logic [4:0] ps_shadow;
    logic strap_done;
    logic [10:0] div_cnt;
    logic [30:0] count;
    wwdt_mode_t mode;
    logic [31:0] rdata;
    logic dev_reset;
    logic wake;
  } wwdt_state_t;

endpackage

// File: design/wwdt_top.sv
// windowed watchdog timer with one control register and clear/set/invert aliases
// assumes configuration straps held stable from reset onward, one 40 MHz clock
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps

module wwdt_top
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_cfg_on,
  input wire logic [4:0] i_config_postscaler,
  input wire logic i_sleep_idle,
  output logic [31:0] o_rdata,
  output logic o_dev_reset,
  output logic o_wake
);

  wwdt_pkg::wwdt_bus_t bus;
  wwdt_pkg::wwdt_state_t s_reg;
  wwdt_pkg::wwdt_state_t s_next;
  logic cfg_sync1_reg;
  logic cfg_sync2_reg;
  logic sleep_sync1_reg;
  logic sleep_sync2_reg;
  logic [4:0] ps_sync1_reg;
  logic [4:0] ps_sync2_reg;

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // ****************************************
  // time-out helpers
  // ****************************************
  // time-out count for a postscaler value: 2^ps ticks, saturating at 2^30
  function automatic logic [30:0] period_of(input logic [4:0] ps);
    logic [30:0] p;
    p = 31'h0;
    if (ps > 5'h1e)
    begin
      p[30] = 1'b1;
    end
    else
    begin
      p[ps] = 1'b1;
    end
    return p;
  endfunction

  // the tick that would reach the period ends it
  function automatic logic at_period(input logic [30:0] cnt, input logic [30:0] per);
    logic [30:0] nxt;
    nxt = cnt + 31'h1;
    return nxt >= per;
  endfunction

  // window opens after three quarters of the period
  function automatic logic window_open(input logic [30:0] cnt, input logic [30:0] per);
    logic [30:0] quarter;
    logic [30:0] start;
    quarter = per >> wwdt_pkg::WIN_SHIFT;
    start = per - quarter;
    return cnt >= start;
  endfunction

  // ****************************************
  // register port helpers
  // ****************************************
  // the four aliases share one decode
  function automatic logic ctrl_decode(input logic [3:0] a);
    logic hit;
    case (a)
      wwdt_pkg::CTRL_OFS,
      wwdt_pkg::CTRL_CLR_OFS,
      wwdt_pkg::CTRL_SET_OFS,
      wwdt_pkg::CTRL_INV_OFS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // only a written one clears; the clear alias never does
  function automatic logic clear_of(input logic d, input logic [3:0] a);
    logic c;
    c = 1'b0;
    if (d && (a != wwdt_pkg::CTRL_CLR_OFS))
    begin
      c = 1'b1;
    end
    return c;
  endfunction

  // control word as software reads it, unimplemented bits zero
  function automatic logic [31:0] read_word(input logic on, input logic [4:0] ps, input logic win);
    logic [31:0] w;
    w = 32'h0;
    w[wwdt_pkg::ON_POS] = on;
    w[wwdt_pkg::PS_MSB:wwdt_pkg::PS_LSB] = ps;
    w[wwdt_pkg::WIN_POS] = win;
    return w;
  endfunction

  // alias write: clear, set or invert the ones of the data
  function automatic logic apply_alias(input logic cur, input logic d, input logic [3:0] a);
    logic r;
    r = cur;
    case (a)
      wwdt_pkg::CTRL_OFS: r = d;
      wwdt_pkg::CTRL_CLR_OFS: r = cur & ~d;
      wwdt_pkg::CTRL_SET_OFS: r = cur | d;
      wwdt_pkg::CTRL_INV_OFS: r = cur ^ d;
      default: r = cur;
    endcase
    return r;
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cfg_sync1_reg <= 1'b0;
      cfg_sync2_reg <= 1'b0;
      sleep_sync1_reg <= 1'b0;
      sleep_sync2_reg <= 1'b0;
    end
    else
    begin
      cfg_sync1_reg <= i_cfg_on;
      cfg_sync2_reg <= cfg_sync1_reg;
      sleep_sync1_reg <= i_sleep_idle;
      sleep_sync2_reg <= sleep_sync1_reg;
    end
  end

  // ****************************************
  // configuration strap synchroniser
  // ****************************************
  // straps are static while running, so a plain two-flop word is safe here
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ps_sync1_reg <= 5'h0;
      ps_sync2_reg <= 5'h0;
    end
    else
    begin
      ps_sync1_reg <= i_config_postscaler;
      ps_sync2_reg <= ps_sync1_reg;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    logic running;
    logic tick;
    logic clr_req;
    logic wr_on;
    logic [30:0] period;
    logic timeout;
    logic ctrl_hit;
    running = 1'b0;
    tick = 1'b0;
    clr_req = 1'b0;
    wr_on = 1'b0;
    period = 31'h0;
    timeout = 1'b0;
    ctrl_hit = 1'b0;
    s_next = s_reg;
    s_next.dev_reset = 1'b0;
    s_next.wake = 1'b0;
    ctrl_hit = ctrl_decode(bus.addr);
    // config enable cannot be stopped by software
    running = cfg_sync2_reg | s_reg.sw_on;
    // shadow taken once, after reset release, through the synchroniser
    // waiting for it to settle keeps the synchroniser's reset zero out of the shadow
    if (!s_reg.strap_done && (s_reg.div_cnt == wwdt_pkg::STRAP_SETTLE))
    begin
      s_next.ps_shadow = ps_sync2_reg;
      s_next.strap_done = 1'b1;
    end
    // divider gives one-cycle low-power oscillator ticks
    // free-running, so the first tick after a clear may come up to one tick early
    tick = 1'b0;
    if (s_reg.div_cnt == wwdt_pkg::LPOSC_DIV_LAST)
    begin
      s_next.div_cnt = 11'h0;
      tick = 1'b1;
    end
    else
    begin
      s_next.div_cnt = s_reg.div_cnt + 11'h1;
    end
    clr_req = 1'b0;
    if (bus.wr && ctrl_hit)
    begin
      wr_on = apply_alias(s_reg.sw_on, bus.wdata[wwdt_pkg::ON_POS], bus.addr);
      s_next.sw_on = wr_on;
      s_next.win_en = apply_alias(s_reg.win_en, bus.wdata[wwdt_pkg::WIN_POS], bus.addr);
      // set or invert of a one counts as a clear too
      clr_req = clear_of(bus.wdata[wwdt_pkg::CLR_POS], bus.addr);
    end
    period = period_of(s_reg.ps_shadow);
    timeout = 1'b0;
    case (s_reg.mode)
      wwdt_pkg::WWDT_RUN:
      begin
        if (!running)
        begin
          s_next.mode = wwdt_pkg::WWDT_STOPPED;
          s_next.count = 31'h0;
        end
        else if (clr_req)
        begin
          // in windowed mode an early clear is a fault
          if (s_reg.win_en && !window_open(s_reg.count, period))
          begin
            timeout = 1'b1;
          end
          s_next.count = 31'h0;
        end
        else if (tick)
        begin
          if (at_period(s_reg.count, period))
          begin
            timeout = 1'b1;
            s_next.count = 31'h0;
          end
          else
          begin
            s_next.count = s_reg.count + 31'h1;
          end
        end
      end
      wwdt_pkg::WWDT_STOPPED:
      begin
        // held at zero so an enable starts the period from a zero count
        s_next.count = 31'h0;
        if (running)
        begin
          s_next.mode = wwdt_pkg::WWDT_RUN;
        end
      end
      wwdt_pkg::WWDT_EXPIRED:
      begin
        // one cycle gap so pulses stay single
        if (running)
        begin
          s_next.mode = wwdt_pkg::WWDT_RUN;
        end
        else
        begin
          s_next.mode = wwdt_pkg::WWDT_STOPPED;
        end
        s_next.count = 31'h0;
      end
      default:
      begin
        s_next.mode = wwdt_pkg::WWDT_STOPPED;
      end
    endcase
    if (timeout)
    begin
      s_next.mode = wwdt_pkg::WWDT_EXPIRED;
      if (sleep_sync2_reg)
      begin
        s_next.wake = 1'b1;
      end
      else
      begin
        s_next.dev_reset = 1'b1;
      end
    end
    // read data stands one cycle, zero otherwise
    s_next.rdata = 32'h0;
    if (bus.rd && ctrl_hit)
    begin
      s_next.rdata = read_word(running, s_reg.ps_shadow, s_reg.win_en);
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_reg.sw_on <= wwdt_pkg::ON_RST;
      s_reg.win_en <= wwdt_pkg::WIN_RST;
      s_reg.ps_shadow <= 5'h0;
      s_reg.strap_done <= 1'b0;
      s_reg.div_cnt <= 11'h0;
      s_reg.count <= 31'h0;
      s_reg.mode <= wwdt_pkg::WWDT_STOPPED;
      s_reg.rdata <= 32'h0;
      s_reg.dev_reset <= 1'b0;
      s_reg.wake <= 1'b0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_rdata = s_reg.rdata;
  assign o_dev_reset = s_reg.dev_reset;
  assign o_wake = s_reg.wake;

endmodule

// File: bench/wwdt_top_chk.sv
// checker for the watchdog register port and event pulses
// assumes it is bound into wwdt_top, one clock domain
`timescale 1ns/1ps
module wwdt_top_chk
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_cfg_on,
  input wire logic [4:0] i_config_postscaler,
  input wire logic i_sleep_idle,
  input wire logic [31:0] o_rdata,
  input wire logic o_dev_reset,
  input wire logic o_wake
);
  // ****
  // helper: edges since reset release
  // ****
  logic [2:0] up_reg;
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
      up_reg <= 3'h0;
    else if (up_reg != 3'h7)
      up_reg <= up_reg + 3'h1;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside read slot");
  a_unimpl_zero: assert property (o_rdata[31:16] == 16'h0 && o_rdata[14:7] == 8'h0 && !o_rdata[0])
    else $error("unimplemented bits nonzero");
  a_unmapped_zero: assert property ($past(i_rd) && $past(i_addr[1:0]) != 2'h0 |-> o_rdata == 32'h0)
    else $error("unmapped read nonzero");
  a_reset_pulse: assert property (o_dev_reset |=> !o_dev_reset)
    else $error("reset request longer than one cycle");
  a_wake_pulse: assert property (o_wake |=> !o_wake)
    else $error("wake request longer than one cycle");
  a_one_event: assert property (!(o_dev_reset && o_wake))
    else $error("reset and wake together");
  a_cfg_reads_on: assert property (i_cfg_on [*5] ##1 (i_rd && i_addr == 4'h0 && up_reg == 3'h7) |=> o_rdata[15])
    else $error("enable bit low with configuration enable");
  a_ps_shadow: assert property (up_reg == 3'h7 && i_rd && i_addr == 4'h0 |=> o_rdata[6:2] == $past(i_config_postscaler))
    else $error("postscaler shadow mismatch");
  c_reset: cover property (o_dev_reset);
  c_wake: cover property (o_wake);
  c_on_read: cover property (i_rd && i_addr == 4'h0 ##1 o_rdata[15]);
endmodule
bind wwdt_top wwdt_top_chk i_wwdt_top_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_cfg_on(i_cfg_on), .i_config_postscaler(i_config_postscaler),
  .i_sleep_idle(i_sleep_idle), .o_rdata(o_rdata), .o_dev_reset(o_dev_reset), .o_wake(o_wake));

// File: bench/wwdt_top_tb_top.sv
// self-checking bench for the windowed watchdog
// assumes the design counts 1250 clocks per oscillator tick
`timescale 1ns/1ps
module wwdt_top_tb_top;
  logic i_sys_clk, i_rst, i_wr, i_rd, i_cfg_on, i_sleep_idle, o_dev_reset, o_wake, on, win;
  logic [3:0] i_addr;
  logic [31:0] i_wdata, o_rdata, d;
  logic [4:0] ps;
  int n_mismatch = 0, checks_done = 0, n_rst = 0, n_wake = 0, n, i;
  wwdt_top i_wwdt_top (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_cfg_on(i_cfg_on), .i_config_postscaler(ps), .i_sleep_idle(i_sleep_idle),
    .o_rdata(o_rdata), .o_dev_reset(o_dev_reset), .o_wake(o_wake));
  initial
  begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  // pulses last a full cycle, so the falling edge sees each once
  always @(negedge i_sys_clk)
  begin
    n_rst += (o_dev_reset === 1'b1);
    n_wake += (o_wake === 1'b1);
  end
  function automatic logic [31:0] ctrl(input logic o, input logic w);
    return {16'h0, o, 8'h0, ps, w, 1'b0};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask
  task automatic wait_ev(input int lim, input bit wk);
    n = 0;
    while (((wk ? o_wake : o_dev_reset) !== 1'b1) && n < lim)
    begin
      @(posedge i_sys_clk);
      #1 n++;
    end
    // let the falling-edge pulse counters update before anyone reads them
    @(negedge i_sys_clk);
    #1;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #(25 * 80000);
    n_mismatch++;
    results();
  end
  initial
  begin
    {i_rst, i_wr, i_rd, i_cfg_on, i_sleep_idle, i_addr, i_wdata} = {1'b1, 40'h0};
    d = $urandom(26683);
    ps = 5'(2 + $urandom % 2);
    repeat (8) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    // the shadow loads once the strap synchroniser has settled
    repeat (3) @(posedge i_sys_clk);
    rd(4'h0, ctrl(0, 0));
    wr(4'h0, 32'hffff_fffe);
    rd(4'h0, ctrl(1, 1));
    wr(4'h3, 32'h0);
    rd(4'h3, 32'h0);
    rd(4'h0, ctrl(1, 1));
    $display("test registers done");
    {on, win} = 2'b11;
    for (i = 0; i < 9; i++)
    begin
      d = $urandom & 32'h8002;
      wr(4'(4 + 4 * (i % 3)), d);
      if (i % 3 == 0)
        {on, win} &= ~{d[15], d[1]};
      else if (i % 3 == 1)
        {on, win} |= {d[15], d[1]};
      else
        {on, win} ^= {d[15], d[1]};
      rd(4'h0, ctrl(on, win));
    end
    wr(4'h0, 32'h8000);
    $display("test aliases done");
    for (i = 0; i < 6; i++)
    begin
      repeat (1250) @(posedge i_sys_clk);
      wr(4'h0, 32'h8001);
      wr(4'h0, 32'h8000);
    end
    chk(32'(n_rst), 32'h0);
    wait_ev((2 ** ps) * 1250 + 1300, 1'b0);
    // n starts two edges after the clear edge
    chk(32'(n + 2 > (2 ** ps - 1) * 1250 && n + 2 <= (2 ** ps) * 1250), 32'h1);
    chk(32'(n_rst), 32'h1);
    $display("test time-out done");
    @(posedge i_sys_clk);
    i_sleep_idle <= 1'b1;
    wait_ev((2 ** ps) * 1250 + 1300, 1'b1);
    chk(32'(n_wake), 32'h1);
    chk(32'(n_rst), 32'h1);
    $display("test wake done");
    @(posedge i_sys_clk);
    i_sleep_idle <= 1'b0;
    wr(4'h0, 32'h0);
    @(posedge i_sys_clk);
    rd(4'h0, ctrl(0, 0));
    @(posedge i_sys_clk);
    i_cfg_on <= 1'b1;
    repeat (6) @(posedge i_sys_clk);
    wr(4'h0, 32'h0);
    rd(4'h0, ctrl(1, 0));
    $display("test configuration enable done");
    // windowed: a clear before the window opens is a time-out
    wr(4'h8, 32'h2);
    rd(4'h0, ctrl(1, 1));
    wr(4'h0, 32'h3);
    repeat (2) @(negedge i_sys_clk);
    chk(32'(n_rst), 32'h2);
    chk(32'(n_wake), 32'h1);
    $display("test window done");
    results();
  end
endmodule
